/* File: dv/ita_indirect_ctl_test.sv */
// self-checking bench of the indirect table access controller
// assumes the design top alone, its register port and response port driven here
`timescale 1ns/1ps
module test_ita_indirect_ctl
    import ita_pkg::*;
;
    localparam int TMO = 12;
    logic clk, rst, reg_wr, reg_rd, rsp_valid, cmd_valid, cmd_write;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] cmd_target;
    logic [1:0] cmd_port;
    logic [11:0] cmd_addr;
    logic [71:0] cmd_wdata, rsp_data, m_word, w;
    int n_fail, checks, seed, i;

    ita_indirect_ctl #(.RSP_TIMEOUT(TMO)) ita_indirect_ctl_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_target(cmd_target), .cmd_port(cmd_port), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, reg_rdata, exp);
    endtask

    function automatic logic [71:0] rnd72;
        rnd72 = 72'({$random(seed), $random(seed), $random(seed)});
    endfunction

    task automatic chk_data;
        for (int k = 0; k < ITA_DATA_BYTES; k++)
            rd(8'(ITA_OFF_DATA_FIRST + k), m_word[71 - 8 * k -: 8], "data byte");
    endtask

    // model of one launch: expected command or error flag
    task automatic launch(input logic [7:0] c, input logic [7:0] l);
        logic [2:0] fn;
        logic [11:0] a;
        logic [3:0] t;
        logic ok;
        fn = c[7:5];
        a = (fn == 3'h0) ? {2'b00, c[1:0], l} : {c[3:0], l};
        t = (fn == 3'h0) ? {2'b00, c[3:2]} : (fn == 3'h1) ? 4'h4 : (fn == 3'h2) ? 4'h5 : (fn == 3'h4) ? 4'h6 : 4'h7;
        ok = (fn inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5}) && !((fn inside {3'h1, 3'h2}) && !(a[11:8] inside {0, 1, 2, 5}));
        wr(ITA_OFF_CTRL_HI, c);
        wr(ITA_OFF_ADDR_LO, l);
        chk("cmd_valid", cmd_valid, ok);
        if (ok)
        begin
            chk("cmd_target", cmd_target, t);
            chk("cmd_addr", cmd_addr, a);
            chk("cmd_write", cmd_write, !c[4]);
            chk("cmd_wdata", cmd_wdata, m_word);
            if (a[11:8] inside {0, 1, 2, 5})
                chk("cmd_port", cmd_port, (a[11:8] == 4'h5) ? 2'h3 : a[9:8]);
        end
        else
        begin
            rd(ITA_OFF_STATUS, 8'h02, "error flag");
            wr(ITA_OFF_STATUS, 8'h02);
            rd(ITA_OFF_STATUS, 8'h00, "error clear");
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim();
    end

    initial
    begin
        seed = 1102;
        n_fail = 0;
        checks = 0;
        m_word = '0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rsp_valid = 1'b0;
        rsp_data = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("cmd_valid rst", cmd_valid, 1'b0);
        chk("cmd_write rst", cmd_write, 1'b1);
        chk("cmd_addr rst", cmd_addr, 12'h000);
        wr(8'h80, 8'h5a);
        for (i = 'h6e; i <= 'h79; i++)
            rd(8'(i), 8'h00, "reset value");
        rd(8'h80, 8'h00, "unmapped");
        $display("test reset done");

        m_word = rnd72();
        for (i = 0; i < ITA_DATA_BYTES; i++)
            wr(8'(ITA_OFF_DATA_FIRST + i), m_word[71 - 8 * i -: 8]);
        chk("cmd_wdata", cmd_wdata, m_word);
        chk_data();
        $display("test data registers done");

        for (i = 0; i < 32; i++)
            launch({3'(i % 8), 1'b0, 2'(i / 8), 2'($random(seed))}, 8'($random(seed)));
        launch(8'h24, 8'h11);
        launch(8'h45, 8'h22);
        launch(8'h27, 8'h33);
        $display("test command decode done");

        launch(8'h19, 8'h6c);
        rd(ITA_OFF_STATUS, 8'h01, "busy");
        wr(ITA_OFF_ADDR_LO, 8'h93);
        chk("cmd_valid busy", cmd_valid, 1'b0);
        w = rnd72();
        @(posedge clk);
        rsp_valid <= 1'b1;
        rsp_data <= w;
        @(posedge clk);
        rsp_valid <= 1'b0;
        m_word = w;
        chk_data();
        rd(ITA_OFF_ADDR_LO, 8'h6c, "addr low kept");
        rd(ITA_OFF_CTRL_HI, 8'h19, "control");
        rd(ITA_OFF_STATUS, 8'h00, "idle");
        $display("test read response done");

        launch(8'h50, 8'h07);
        repeat (TMO + 3) @(posedge clk);
        rd(ITA_OFF_STATUS, 8'h04, "timeout flag");
        @(posedge clk);
        rsp_valid <= 1'b1;
        rsp_data <= ~w;
        @(posedge clk);
        rsp_valid <= 1'b0;
        chk_data();
        wr(ITA_OFF_STATUS, 8'h04);
        rd(ITA_OFF_STATUS, 8'h00, "timeout clear");
        $display("test timeout done");
        end_sim();
    end
endmodule

/* File: hdl/ita_dec_if.sv */
// carrier between controller and its target decoder
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface ita_dec_if;
    import ita_pkg::*;
    logic [7:0] ctrl;
    logic [7:0] addr_lo;
    ita_target_t target;
    logic [11:0] addr;
    logic [1:0] port_idx;
    logic legal;
    modport ctl (output ctrl, output addr_lo, input target, input addr, input port_idx, input legal);
    modport dec (input ctrl, input addr_lo, output target, output addr, output port_idx, output legal);
endinterface

/* File: hdl/ita_indirect_ctl.sv */
// indirect table access controller: control, address and data registers
// assumes table engines outside answer reads with rsp_valid and rsp_data
`timescale 1ns/1ps
module ita_indirect_ctl
    import ita_pkg::*;
#(
    parameter logic [3:0] PORT1_CODE = 4'h1,
    parameter logic [3:0] PORT2_CODE = 4'h2,
    parameter int RSP_TIMEOUT = ITA_RSP_TIMEOUT_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [3:0] cmd_target,
    output logic [1:0] cmd_port,
    output logic [11:0] cmd_addr,
    output logic [ITA_WORD_W-1:0] cmd_wdata,
    input wire logic rsp_valid,
    input wire logic [ITA_WORD_W-1:0] rsp_data
);
    localparam int TMO_W = $clog2(RSP_TIMEOUT + 1);
    localparam int WAIT_BOUND = RSP_TIMEOUT + 1;

    if (RSP_TIMEOUT < 1 || RSP_TIMEOUT > 1000)
    begin : g_bad_tmo
        $error("RSP_TIMEOUT out of range");
    end
    if (PORT1_CODE == PORT2_CODE || PORT1_CODE == ITA_PSEL_GLOBAL || PORT1_CODE == ITA_PSEL_PORT3
        || PORT2_CODE == ITA_PSEL_GLOBAL || PORT2_CODE == ITA_PSEL_PORT3)
    begin : g_bad_port
        $error("port codes must be distinct");
    end

    ita_state_t state_reg;
    logic [7:0] ctrl_hi_reg;
    logic [7:0] addr_lo_reg;
    logic [7:0] data_reg [ITA_DATA_BYTES];
    logic [7:0] rdata_reg;
    logic [7:0] rd_next;
    logic [TMO_W-1:0] tmo_reg;
    logic err_reg;
    logic tmo_flag_reg;
    logic launch;
    logic rsp_take;
    logic timed_out;
    logic in_data;
    logic [7:0] data_idx;
    ita_dec_if dif ();
    logic [2:0] fn_sel;
    logic [1:0] tbl_sel;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    assign dif.ctrl = ctrl_hi_reg;
    assign dif.addr_lo = addr_lo_reg;

    ita_target_dec #(
        .PORT1_CODE(PORT1_CODE),
        .PORT2_CODE(PORT2_CODE)
    ) u_dec (
        .dif(dif)
    );

    assign launch = reg_wr && reg_addr == ITA_OFF_ADDR_LO && state_reg == ITA_S_IDLE;
    assign rsp_take = state_reg == ITA_S_WAIT && rsp_valid;
    assign timed_out = state_reg == ITA_S_WAIT && !rsp_valid && tmo_reg == TMO_W'(RSP_TIMEOUT - 1);
    assign in_data = reg_addr >= ITA_OFF_DATA_FIRST && reg_addr <= ITA_OFF_DATA_LAST;
    assign data_idx = reg_addr - ITA_OFF_DATA_FIRST;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_hi_reg <= ITA_CTRL_RST;
        else if (reg_wr && reg_addr == ITA_OFF_CTRL_HI)
            ctrl_hi_reg <= reg_wdata;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            addr_lo_reg <= ITA_ADDR_RST;
        else if (launch)
            addr_lo_reg <= reg_wdata;
    end

    // command sequencing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ITA_S_IDLE;
        end
        else
        begin
            unique case (state_reg)
                ITA_S_IDLE:
                    if (launch)
                        state_reg <= ITA_S_ISSUE;
                ITA_S_ISSUE:
                    if (dif.legal && ctrl_hi_reg[ITA_DIR_BIT])
                        state_reg <= ITA_S_WAIT;
                    else
                        state_reg <= ITA_S_IDLE;
                ITA_S_WAIT:
                    if (rsp_valid || timed_out)
                        state_reg <= ITA_S_IDLE;
                default:
                    state_reg <= ITA_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tmo_reg <= '0;
        else if (state_reg != ITA_S_WAIT)
            tmo_reg <= '0;
        else
            tmo_reg <= tmo_reg + 1'b1;
    end

    // reserved function flagged, set beats clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            err_reg <= 1'b0;
        else if (state_reg == ITA_S_ISSUE && !dif.legal)
            err_reg <= 1'b1;
        else if (reg_wr && reg_addr == ITA_OFF_STATUS && reg_wdata[ITA_ST_ERR])
            err_reg <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tmo_flag_reg <= 1'b0;
        else if (timed_out)
            tmo_flag_reg <= 1'b1;
        else if (reg_wr && reg_addr == ITA_OFF_STATUS && reg_wdata[ITA_ST_TMO])
            tmo_flag_reg <= 1'b0;
    end

    for (genvar i = 0; i < ITA_DATA_BYTES; i++)
    begin : g_data
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
                data_reg[i] <= ITA_DATA_RST;
            else if (rsp_take)
                data_reg[i] <= rsp_data[ITA_WORD_W-1-8*i -: 8];
            else if (reg_wr && reg_addr == 8'(ITA_OFF_DATA_FIRST + i))
                data_reg[i] <= reg_wdata;
        end
        assign cmd_wdata[ITA_WORD_W-1-8*i -: 8] = data_reg[i];
    end

    assign cmd_valid = state_reg == ITA_S_ISSUE && dif.legal;
    assign cmd_write = !ctrl_hi_reg[ITA_DIR_BIT];
    assign cmd_target = dif.target;
    assign cmd_port = dif.port_idx;
    assign cmd_addr = dif.addr;

    always_comb
    begin
        rd_next = 8'h00;
        if (in_data)
            rd_next = data_reg[data_idx[3:0]];
        else if (reg_addr == ITA_OFF_CTRL_HI)
            rd_next = ctrl_hi_reg;
        else if (reg_addr == ITA_OFF_ADDR_LO)
            rd_next = addr_lo_reg;
        else if (reg_addr == ITA_OFF_STATUS)
        begin
            rd_next[ITA_ST_BUSY] = state_reg != ITA_S_IDLE;
            rd_next[ITA_ST_ERR] = err_reg;
            rd_next[ITA_ST_TMO] = tmo_flag_reg;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= 8'h00;
        else if (reg_rd)
            rdata_reg <= rd_next;
        else
            rdata_reg <= 8'h00;
    end

    assign reg_rdata = rdata_reg;

    // fields watched by the checks below
    assign fn_sel = ctrl_hi_reg[ITA_FN_HI:ITA_FN_LO];
    assign tbl_sel = ctrl_hi_reg[ITA_TSEL_HI:ITA_TSEL_LO];

    launch_issue_a: assert property (launch |=> state_reg == ITA_S_ISSUE && addr_lo_reg == $past(reg_wdata))
        else $error("launch did not issue");
    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command longer than one cycle");
    busy_ignore_a: assert property (reg_wr && reg_addr == ITA_OFF_ADDR_LO && state_reg != ITA_S_IDLE
        |=> $stable(addr_lo_reg) && !cmd_valid)
        else $error("launch accepted while busy");
    dir_read_a: assert property (cmd_valid && !cmd_write |=> state_reg == ITA_S_WAIT)
        else $error("read did not wait");
    dir_write_a: assert property (cmd_valid && cmd_write |=> state_reg == ITA_S_IDLE)
        else $error("write did not finish");
    table_static_a: assert property (cmd_valid && fn_sel == ITA_FN_TABLE && tbl_sel == ITA_TS_STATIC
        |-> cmd_target == ITA_TGT_STATIC)
        else $error("static table not chosen");
    table_vlan_a: assert property (cmd_valid && fn_sel == ITA_FN_TABLE && tbl_sel == ITA_TS_VLAN
        |-> cmd_target == ITA_TGT_VLAN)
        else $error("vlan table not chosen");
    table_dyn_a: assert property (cmd_valid && fn_sel == ITA_FN_TABLE && tbl_sel == ITA_TS_DYNAMIC
        |-> cmd_target == ITA_TGT_DYNAMIC)
        else $error("dynamic table not chosen");
    table_mib_a: assert property (cmd_valid && fn_sel == ITA_FN_TABLE && tbl_sel == ITA_TS_MIB
        |-> cmd_target == ITA_TGT_MIB && cmd_addr[11:10] == 2'h0)
        else $error("mib table not chosen");
    eee_addr_a: assert property (cmd_valid && fn_sel == ITA_FN_EEE
        |-> cmd_target == ITA_TGT_EEE && cmd_addr[11:8] == ctrl_hi_reg[ITA_TSEL_HI:ITA_AHI_LO])
        else $error("eee address wrong");
    addr_top_a: assert property (cmd_valid && fn_sel != ITA_FN_TABLE |-> cmd_addr[11:10] == tbl_sel)
        else $error("address 11:10 wrong");
    acl_addr_a: assert property (cmd_valid && fn_sel == ITA_FN_ACL
        |-> cmd_target == ITA_TGT_ACL && cmd_addr[7:0] == addr_lo_reg)
        else $error("acl address wrong");
    addr_low_a: assert property (cmd_valid |-> cmd_addr[7:0] == addr_lo_reg)
        else $error("address 7:0 wrong");
    rsvd_refuse_a: assert property (state_reg == ITA_S_ISSUE && fn_sel == ITA_FN_RSVD
        |-> !cmd_valid ##1 err_reg && state_reg == ITA_S_IDLE)
        else $error("reserved function issued");
    err_set_a: assert property (state_reg == ITA_S_ISSUE && !dif.legal |=> err_reg)
        else $error("error flag not set");
    pme_tgt_a: assert property (cmd_valid && fn_sel == ITA_FN_PME |-> cmd_target == ITA_TGT_PME)
        else $error("power management target not chosen");
    cable_tgt_a: assert property (cmd_valid && fn_sel == ITA_FN_CABLE |-> cmd_target == ITA_TGT_CABLE)
        else $error("cable diagnosis not chosen");
    port3_code_a: assert property (cmd_valid && (fn_sel == ITA_FN_EEE || fn_sel == ITA_FN_ACL)
        && cmd_addr[11:8] == ITA_PSEL_PORT3 |-> cmd_port == 2'h3)
        else $error("port three code wrong");
    port_glob_a: assert property (cmd_valid && (fn_sel == ITA_FN_EEE || fn_sel == ITA_FN_ACL)
        && cmd_addr[11:8] == ITA_PSEL_GLOBAL |-> cmd_port == 2'h0)
        else $error("global code wrong");
    addr_mid_a: assert property (cmd_valid |-> cmd_addr[9:8] == ctrl_hi_reg[ITA_AHI_HI:ITA_AHI_LO])
        else $error("address 9:8 wrong");
    data_write_a: assert property (reg_wr && reg_addr == ITA_OFF_DATA_LAST && !rsp_take
        |=> data_reg[ITA_DATA_BYTES-1] == $past(reg_wdata))
        else $error("data write lost");
    data_order_a: assert property (rsp_take |=> data_reg[0] == $past(rsp_data[ITA_WORD_W-1 -: 8])
        && data_reg[ITA_DATA_BYTES-1] == $past(rsp_data[7:0]))
        else $error("data byte order wrong");
    read_bound_a: assert property ($rose(state_reg == ITA_S_WAIT) |-> ##[1:WAIT_BOUND] state_reg == ITA_S_IDLE)
        else $error("read never completed");
    tmo_flag_a: assert property (timed_out |=> tmo_flag_reg && state_reg == ITA_S_IDLE)
        else $error("timeout not flagged");
    rsp_ignore_a: assert property (rsp_valid && state_reg != ITA_S_WAIT && !reg_wr |=> $stable(cmd_wdata))
        else $error("stray answer stored");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    write_cmd_c: cover property (cmd_valid && cmd_write);
    read_done_c: cover property (rsp_take);
    timeout_c: cover property (timed_out);
    rsvd_c: cover property (state_reg == ITA_S_ISSUE && !dif.legal);
    busy_launch_c: cover property (reg_wr && reg_addr == ITA_OFF_ADDR_LO && state_reg != ITA_S_IDLE);
endmodule

/* File: hdl/ita_pkg.sv */
// constants and types of the indirect table access controller
// assumes an 8-bit register port and one 200 MHz core clock
//
// Behaviour
// - function select zero picks a table
// - function 001 targets energy-efficient-Ethernet registers
// - function 010 targets access-control-list registers
// - function 100 power management; 011 reserved
// - function 101 routes to cable diagnosis
// - direction bit one reads, zero writes
// - table select: static, vlan, dynamic, mib
// - nonzero function: bits 3:2 are address 11:10
// - port code 0000 global, 0101 port 3
// - control bits 1:0 give address 9:8
// - second control register holds address 7:0
// - writing low address byte launches the command
// - data registers carry entry for every target
// - nine data bytes form 72-bit word, msb first
package ita_pkg;
    localparam logic [7:0] ITA_OFF_CTRL_HI = 8'h6e;
    localparam logic [7:0] ITA_OFF_ADDR_LO = 8'h6f;
    localparam logic [7:0] ITA_OFF_DATA_FIRST = 8'h70;
    localparam logic [7:0] ITA_OFF_DATA_LAST = 8'h78;
    localparam logic [7:0] ITA_OFF_STATUS = 8'h79;
    localparam int ITA_DATA_BYTES = 9;
    localparam int ITA_WORD_W = 72;
    localparam logic [7:0] ITA_CTRL_RST = 8'h00;
    localparam logic [7:0] ITA_ADDR_RST = 8'h00;
    localparam logic [7:0] ITA_DATA_RST = 8'h00;
    localparam int ITA_FN_HI = 7;
    localparam int ITA_FN_LO = 5;
    localparam int ITA_DIR_BIT = 4;
    localparam int ITA_TSEL_HI = 3;
    localparam int ITA_TSEL_LO = 2;
    localparam int ITA_AHI_HI = 1;
    localparam int ITA_AHI_LO = 0;
    localparam logic [2:0] ITA_FN_TABLE = 3'h0;
    localparam logic [2:0] ITA_FN_EEE = 3'h1;
    localparam logic [2:0] ITA_FN_ACL = 3'h2;
    localparam logic [2:0] ITA_FN_RSVD = 3'h3;
    localparam logic [2:0] ITA_FN_PME = 3'h4;
    localparam logic [2:0] ITA_FN_CABLE = 3'h5;
    localparam logic [1:0] ITA_TS_STATIC = 2'h0;
    localparam logic [1:0] ITA_TS_VLAN = 2'h1;
    localparam logic [1:0] ITA_TS_DYNAMIC = 2'h2;
    localparam logic [1:0] ITA_TS_MIB = 2'h3;
    localparam logic [3:0] ITA_PSEL_GLOBAL = 4'h0;
    localparam logic [3:0] ITA_PSEL_PORT3 = 4'h5;
    localparam int ITA_ST_BUSY = 0;
    localparam int ITA_ST_ERR = 1;
    localparam int ITA_ST_TMO = 2;
    localparam int ITA_CLK_PERIOD_PS = 5000;
    localparam int ITA_RSP_TIMEOUT_NS = 100;
    localparam int ITA_RSP_TIMEOUT_CYC = (ITA_RSP_TIMEOUT_NS * 1000) / ITA_CLK_PERIOD_PS;

    typedef enum logic [3:0]
    {
        ITA_TGT_STATIC = 4'h0,
        ITA_TGT_VLAN = 4'h1,
        ITA_TGT_DYNAMIC = 4'h2,
        ITA_TGT_MIB = 4'h3,
        ITA_TGT_EEE = 4'h4,
        ITA_TGT_ACL = 4'h5,
        ITA_TGT_PME = 4'h6,
        ITA_TGT_CABLE = 4'h7,
        ITA_TGT_NONE = 4'hf
    } ita_target_t;

    typedef enum logic [1:0]
    {
        ITA_S_IDLE = 2'h0,
        ITA_S_ISSUE = 2'h1,
        ITA_S_WAIT = 2'h3
    } ita_state_t;
endpackage

/* File: hdl/ita_target_dec.sv */
// decodes control bytes into target space, address and port
// assumes inputs come from registers on the core clock
`timescale 1ns/1ps
module ita_target_dec
    import ita_pkg::*;
#(
    parameter logic [3:0] PORT1_CODE = 4'h1,
    parameter logic [3:0] PORT2_CODE = 4'h2
)
(
    ita_dec_if.dec dif
);
    logic [2:0] func;
    logic [1:0] tsel;
    logic [3:0] psel;

    assign func = dif.ctrl[ITA_FN_HI:ITA_FN_LO];
    assign tsel = dif.ctrl[ITA_TSEL_HI:ITA_TSEL_LO];
    assign psel = dif.addr[11:8];

    always_comb
    begin
        dif.addr = {dif.ctrl[ITA_TSEL_HI:ITA_TSEL_LO], dif.ctrl[ITA_AHI_HI:ITA_AHI_LO], dif.addr_lo};
        if (func == ITA_FN_TABLE)
        begin
            dif.addr[11:10] = 2'h0;
        end
    end

    always_comb
    begin
        dif.port_idx = 2'h0;
        if (psel == PORT1_CODE)
            dif.port_idx = 2'h1;
        else if (psel == PORT2_CODE)
            dif.port_idx = 2'h2;
        else if (psel == ITA_PSEL_PORT3)
            dif.port_idx = 2'h3;
    end

    always_comb
    begin
        dif.target = ITA_TGT_NONE;
        dif.legal = 1'b1;
        unique case (func)
            ITA_FN_TABLE:
            begin
                unique case (tsel)
                    ITA_TS_STATIC: dif.target = ITA_TGT_STATIC;
                    ITA_TS_VLAN: dif.target = ITA_TGT_VLAN;
                    ITA_TS_DYNAMIC: dif.target = ITA_TGT_DYNAMIC;
                    ITA_TS_MIB: dif.target = ITA_TGT_MIB;
                endcase
            end
            ITA_FN_EEE: dif.target = ITA_TGT_EEE;
            ITA_FN_ACL: dif.target = ITA_TGT_ACL;
            ITA_FN_PME: dif.target = ITA_TGT_PME;
            ITA_FN_CABLE: dif.target = ITA_TGT_CABLE;
            default: dif.legal = 1'b0;
        endcase
        if ((func == ITA_FN_EEE || func == ITA_FN_ACL) && psel != ITA_PSEL_GLOBAL
            && psel != PORT1_CODE && psel != PORT2_CODE && psel != ITA_PSEL_PORT3)
        begin
            dif.legal = 1'b0;
        end
    end
endmodule
